// >>> core/bfpc_top.v
// two 64-word queues and two mailboxes with per-port parity check and generation
// assumes all port controls synchronous to clock_i; port buses split in/out/enable
`timescale 1ns/100ps
`default_nettype none
`include "bfpc_regs.vh"

module bfpc_top (
  input  wire                      clock_i,
  input  wire                      sys_rst_i,
  input  wire                      odd_even_sel_i,
  input  wire [`BFPC_WORD_W-1:0]   port_a_bus_i,
  output reg  [`BFPC_WORD_W-1:0]   port_a_bus_o,
  output reg                       port_a_bus_oe_n_o,
  input  wire                      port_a_chip_sel_n_i,
  input  wire                      port_a_write_read_i,
  input  wire                      port_a_enable_i,
  input  wire                      port_a_mailbox_sel_i,
  input  wire                      port_a_par_gen_sel_i,
  output reg                       port_a_parity_err_n_o,
  output reg                       port_a_empty_n_o,
  output reg                       port_a_full_n_o,
  output reg                       port_a_almost_empty_n_o,
  output reg                       port_a_almost_full_n_o,
  input  wire [`BFPC_WORD_W-1:0]   port_b_bus_i,
  output reg  [`BFPC_WORD_W-1:0]   port_b_bus_o,
  output reg                       port_b_bus_oe_n_o,
  input  wire                      port_b_chip_sel_n_i,
  input  wire                      port_b_write_read_i,
  input  wire                      port_b_enable_i,
  input  wire                      port_b_mailbox_sel_i,
  input  wire                      port_b_par_gen_sel_i,
  output reg                       port_b_parity_err_n_o,
  output reg                       port_b_empty_n_o,
  output reg                       port_b_full_n_o,
  output reg                       port_b_almost_empty_n_o,
  output reg                       port_b_almost_full_n_o
);

  // one tree per byte; with the top bit forced low it yields the parity to insert
  function [`BFPC_NBYTES-1:0] bfpc_trees;
    input [`BFPC_WORD_W-1:0] w;
    input                    odd;
    integer i;
    begin
      for (i = 0; i < `BFPC_NBYTES; i = i + 1) begin
        bfpc_trees[i] = odd ? ~(^w[i*`BFPC_BYTE_W +: `BFPC_BYTE_W])
                            : (^w[i*`BFPC_BYTE_W +: `BFPC_BYTE_W]); // RQ5
      end
    end
  endfunction

  function [`BFPC_WORD_W-1:0] bfpc_strip;
    input [`BFPC_WORD_W-1:0] w;
    integer i;
    begin
      bfpc_strip = w;
      for (i = 0; i < `BFPC_NBYTES; i = i + 1) begin
        bfpc_strip[i*`BFPC_BYTE_W + `BFPC_PAR_BIT] = 1'b0; // RQ10
      end
    end
  endfunction

  function [`BFPC_WORD_W-1:0] bfpc_insert;
    input [`BFPC_WORD_W-1:0] w;
    input [`BFPC_NBYTES-1:0] p;
    integer i;
    begin
      bfpc_insert = w;
      for (i = 0; i < `BFPC_NBYTES; i = i + 1) begin
        bfpc_insert[i*`BFPC_BYTE_W + `BFPC_PAR_BIT] = p[i]; // RQ10
      end
    end
  endfunction

  function [`BFPC_WORD_W-1:0] bfpc_gen;
    input [`BFPC_WORD_W-1:0] w;
    input                    odd;
    begin
      bfpc_gen = bfpc_insert(w, bfpc_trees(bfpc_strip(w), odd));
    end
  endfunction

  // port decode
  wire a_rd_sel = ~port_a_chip_sel_n_i & ~port_a_write_read_i & port_a_enable_i;
  wire a_wr_sel = ~port_a_chip_sel_n_i &  port_a_write_read_i & port_a_enable_i;
  wire b_rd_sel = ~port_b_chip_sel_n_i & ~port_b_write_read_i & port_b_enable_i;
  wire b_wr_sel = ~port_b_chip_sel_n_i &  port_b_write_read_i & port_b_enable_i;

  wire ab_q_wr = a_wr_sel & ~port_a_mailbox_sel_i & port_a_full_n_o;   // RQ18
  wire ba_q_rd = a_rd_sel & ~port_a_mailbox_sel_i & port_a_empty_n_o;  // RQ18
  wire ba_q_wr = b_wr_sel & ~port_b_mailbox_sel_i & port_b_full_n_o;   // RQ18
  wire ab_q_rd = b_rd_sel & ~port_b_mailbox_sel_i & port_b_empty_n_o;  // RQ18
  wire a_mb_rd = a_rd_sel & port_a_mailbox_sel_i;
  wire b_mb_rd = b_rd_sel & port_b_mailbox_sel_i;
  wire a_mb_gen = a_mb_rd & port_a_par_gen_sel_i; // RQ13
  wire b_mb_gen = b_mb_rd & port_b_par_gen_sel_i; // RQ13

  // pointers, extra bit tells full from empty
  reg  [`BFPC_PTR_W-1:0] ab_wr_ptr_r;
  reg  [`BFPC_PTR_W-1:0] ab_rd_ptr_r;
  reg  [`BFPC_PTR_W-1:0] ba_wr_ptr_r;
  reg  [`BFPC_PTR_W-1:0] ba_rd_ptr_r;
  reg  [`BFPC_PTR_W-1:0] ab_wr_sync_r;
  reg  [`BFPC_PTR_W-1:0] ab_rd_sync_r;
  reg  [`BFPC_PTR_W-1:0] ba_wr_sync_r;
  reg  [`BFPC_PTR_W-1:0] ba_rd_sync_r;
  reg  [`BFPC_WORD_W-1:0] a_to_b_mailbox_r;
  reg  [`BFPC_WORD_W-1:0] b_to_a_mailbox_r;
  reg  [`BFPC_WORD_W-1:0] a_q_out_r;
  reg  [`BFPC_WORD_W-1:0] b_q_out_r;

  wire [`BFPC_PTR_W-1:0] ab_wr_ptr_nxt = ab_wr_ptr_r + {{(`BFPC_PTR_W-1){1'b0}}, ab_q_wr};
  wire [`BFPC_PTR_W-1:0] ab_rd_ptr_nxt = ab_rd_ptr_r + {{(`BFPC_PTR_W-1){1'b0}}, ab_q_rd};
  wire [`BFPC_PTR_W-1:0] ba_wr_ptr_nxt = ba_wr_ptr_r + {{(`BFPC_PTR_W-1){1'b0}}, ba_q_wr};
  wire [`BFPC_PTR_W-1:0] ba_rd_ptr_nxt = ba_rd_ptr_r + {{(`BFPC_PTR_W-1){1'b0}}, ba_q_rd};

  // counts seen by each side: own pointer fresh, far pointer one stage late
  wire [`BFPC_PTR_W-1:0] ab_wr_cnt_nxt = ab_wr_ptr_nxt - ab_rd_sync_r;
  wire [`BFPC_PTR_W-1:0] ab_rd_cnt_nxt = ab_wr_sync_r - ab_rd_ptr_nxt;
  wire [`BFPC_PTR_W-1:0] ba_wr_cnt_nxt = ba_wr_ptr_nxt - ba_rd_sync_r;
  wire [`BFPC_PTR_W-1:0] ba_rd_cnt_nxt = ba_wr_sync_r - ba_rd_ptr_nxt;

  wire [`BFPC_WORD_W-1:0] ab_ram_q;
  wire [`BFPC_WORD_W-1:0] ba_ram_q;

  // queue storage keeps the raw word; parity is only made on the way out
  bfpc_ram u_a_to_b_queue (
    .clock_i   (clock_i),
    .wr_en_i   (ab_q_wr),
    .wr_addr_i (ab_wr_ptr_r[`BFPC_ADDR_W-1:0]),
    .wr_data_i (port_a_bus_i),                   // RQ9
    .rd_addr_i (ab_rd_ptr_nxt[`BFPC_ADDR_W-1:0]),
    .rd_data_o (ab_ram_q)
  );

  bfpc_ram u_b_to_a_queue (
    .clock_i   (clock_i),
    .wr_en_i   (ba_q_wr),
    .wr_addr_i (ba_wr_ptr_r[`BFPC_ADDR_W-1:0]),
    .wr_data_i (port_b_bus_i),                   // RQ9
    .rd_addr_i (ba_rd_ptr_nxt[`BFPC_ADDR_W-1:0]),
    .rd_data_o (ba_ram_q)
  );

  // shared trees: check the bus, or generate for the mailbox this port reads
  wire [`BFPC_WORD_W-1:0] a_tree_in = a_mb_gen ? bfpc_strip(b_to_a_mailbox_r)
                                               : port_a_bus_i;                  // RQ12
  wire [`BFPC_WORD_W-1:0] b_tree_in = b_mb_gen ? bfpc_strip(a_to_b_mailbox_r)
                                               : port_b_bus_i;                  // RQ12
  wire [`BFPC_NBYTES-1:0] a_tree = bfpc_trees(a_tree_in, odd_even_sel_i); // RQ1 RQ3
  wire [`BFPC_NBYTES-1:0] b_tree = bfpc_trees(b_tree_in, odd_even_sel_i); // RQ1 RQ4

  // mailbox contents never change on read; only the driven copy is altered
  wire [`BFPC_WORD_W-1:0] a_mb_out = a_mb_gen ? bfpc_insert(b_to_a_mailbox_r, a_tree)
                                              : b_to_a_mailbox_r;               // RQ13 RQ20
  wire [`BFPC_WORD_W-1:0] b_mb_out = b_mb_gen ? bfpc_insert(a_to_b_mailbox_r, b_tree)
                                              : a_to_b_mailbox_r;               // RQ13 RQ20

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ab_wr_ptr_r  <= {`BFPC_PTR_W{1'b0}};
      ab_rd_ptr_r  <= {`BFPC_PTR_W{1'b0}};
      ba_wr_ptr_r  <= {`BFPC_PTR_W{1'b0}};
      ba_rd_ptr_r  <= {`BFPC_PTR_W{1'b0}};
      ab_wr_sync_r <= {`BFPC_PTR_W{1'b0}};
      ab_rd_sync_r <= {`BFPC_PTR_W{1'b0}};
      ba_wr_sync_r <= {`BFPC_PTR_W{1'b0}};
      ba_rd_sync_r <= {`BFPC_PTR_W{1'b0}};
    end else begin
      ab_wr_ptr_r  <= ab_wr_ptr_nxt;
      ab_rd_ptr_r  <= ab_rd_ptr_nxt;
      ba_wr_ptr_r  <= ba_wr_ptr_nxt;
      ba_rd_ptr_r  <= ba_rd_ptr_nxt;
      // first stage of two toward the far side's flags
      ab_wr_sync_r <= ab_wr_ptr_r; // RQ14 RQ16
      ab_rd_sync_r <= ab_rd_ptr_r; // RQ15 RQ17
      ba_wr_sync_r <= ba_wr_ptr_r; // RQ14 RQ16
      ba_rd_sync_r <= ba_rd_ptr_r; // RQ15 RQ17
    end
  end

  // flags: second stage, so a far-side event shows on the second edge after it
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_a_empty_n_o        <= 1'b0;
      port_a_almost_empty_n_o <= 1'b0;
      port_a_full_n_o         <= 1'b1;
      port_a_almost_full_n_o  <= 1'b1;
      port_b_empty_n_o        <= 1'b0;
      port_b_almost_empty_n_o <= 1'b0;
      port_b_full_n_o         <= 1'b1;
      port_b_almost_full_n_o  <= 1'b1;
    end else begin
      port_b_empty_n_o        <= (ab_rd_cnt_nxt != {`BFPC_PTR_W{1'b0}});          // RQ14
      port_b_almost_empty_n_o <= (ab_rd_cnt_nxt > `BFPC_AE_AF_OFS);              // RQ16
      port_a_full_n_o         <= (ab_wr_cnt_nxt != `BFPC_DEPTH);                 // RQ15
      port_a_almost_full_n_o  <= (ab_wr_cnt_nxt < (`BFPC_DEPTH - `BFPC_AE_AF_OFS)); // RQ17
      port_a_empty_n_o        <= (ba_rd_cnt_nxt != {`BFPC_PTR_W{1'b0}});          // RQ14
      port_a_almost_empty_n_o <= (ba_rd_cnt_nxt > `BFPC_AE_AF_OFS);              // RQ16
      port_b_full_n_o         <= (ba_wr_cnt_nxt != `BFPC_DEPTH);                 // RQ15
      port_b_almost_full_n_o  <= (ba_wr_cnt_nxt < (`BFPC_DEPTH - `BFPC_AE_AF_OFS)); // RQ17
    end
  end

  // mailboxes and queue output registers
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      a_to_b_mailbox_r <= `BFPC_WORD_RST;
      b_to_a_mailbox_r <= `BFPC_WORD_RST;
      a_q_out_r        <= `BFPC_WORD_RST;
      b_q_out_r        <= `BFPC_WORD_RST;
    end else begin
      if (a_wr_sel & port_a_mailbox_sel_i) begin
        a_to_b_mailbox_r <= port_a_bus_i; // RQ19 RQ9
      end
      if (b_wr_sel & port_b_mailbox_sel_i) begin
        b_to_a_mailbox_r <= port_b_bus_i; // RQ19 RQ9
      end
      // selects sampled only on the edge that loads a new word
      if (ba_q_rd) begin
        a_q_out_r <= port_a_par_gen_sel_i ? bfpc_gen(ba_ram_q, odd_even_sel_i)
                                          : ba_ram_q;                           // RQ11 RQ8 RQ20
      end
      if (ab_q_rd) begin
        b_q_out_r <= port_b_par_gen_sel_i ? bfpc_gen(ab_ram_q, odd_even_sel_i)
                                          : ab_ram_q;                           // RQ11 RQ8 RQ20
      end
    end
  end

  // bus drivers and error flags; output enable low while driving
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_a_bus_o          <= `BFPC_WORD_RST;
      port_b_bus_o          <= `BFPC_WORD_RST;
      port_a_bus_oe_n_o     <= 1'b1;
      port_b_bus_oe_n_o     <= 1'b1;
      port_a_parity_err_n_o <= 1'b1;
      port_b_parity_err_n_o <= 1'b1;
    end else begin
      port_a_bus_o          <= a_mb_rd ? a_mb_out : a_q_out_r;    // RQ18 RQ8
      port_b_bus_o          <= b_mb_rd ? b_mb_out : b_q_out_r;    // RQ18 RQ8
      port_a_bus_oe_n_o     <= ~a_rd_sel;
      port_b_bus_oe_n_o     <= ~b_rd_sel;
      port_a_parity_err_n_o <= a_mb_gen | ~(|a_tree);             // RQ2 RQ6
      port_b_parity_err_n_o <= b_mb_gen | ~(|b_tree);             // RQ2 RQ7
    end
  end

endmodule
`default_nettype wire

// >>> core/bfpc_regs.vh
// constants shared by the bidirectional queue parity core
// assumes one clock for both ports and inputs synchronous to it
//
// Notes on behaviour
// [RQ1] check every input byte per port, odd or even by shared sense select
// [RQ2] any failing byte drives that port's error flag low, else high
// [RQ3] port a bytes are bits 0-8, 9-17, 18-26, 27-35; top bit is parity
// [RQ4] port b bytes are bits 0-8, 9-17, 18-26, 27-35; top bit is parity
// [RQ5] odd sense: error on odd count of lows; even sense: on even count
// [RQ6] port a error flag held high during parity-generated b-to-a mailbox read
// [RQ7] port b error flag held high during parity-generated a-to-b mailbox read
// [RQ8] generate select high makes parity for reads from queue or mailbox
// [RQ9] writes to queue or mailbox store all 36 bits unchanged
// [RQ10] generated parity from low eight bits replaces stored top bit on output
// [RQ11] queue parity made between array read and output register load
// [RQ12] each port's check trees also generate parity for the mailbox it reads
// [RQ13] mailbox parity only on selected mailbox read with generate high
// [RQ14] empty flag rises on second reading-side edge after the write
// [RQ15] full flag rises on second writing-side edge after the read
// [RQ16] almost-empty flag rises on second reading-side edge after the write
// [RQ17] almost-full flag rises on second writing-side edge after the read
// [RQ18] mailbox select high picks mailbox, low picks queue
// [RQ19] mailboxes load from their writing port on a selected mailbox write
// [RQ20] generate select low passes stored top bits unchanged
`ifndef BFPC_REGS_VH
`define BFPC_REGS_VH

`define BFPC_WORD_W      36
`define BFPC_BYTE_W      9
`define BFPC_NBYTES      4
`define BFPC_PAR_BIT     8
`define BFPC_ADDR_W      6
`define BFPC_PTR_W       7
`define BFPC_DEPTH       7'h40
`define BFPC_AE_AF_OFS   7'h08
`define BFPC_WORD_RST    36'h000000000

`endif

// >>> core/bfpc_ram.v
// one queue's storage: 64 words of 36 bits, one write and one read port
// read data is registered; the caller presents the next read address early
`timescale 1ns/100ps
`default_nettype none
`include "bfpc_regs.vh"

module bfpc_ram (
  input  wire                      clock_i,
  input  wire                      wr_en_i,
  input  wire [`BFPC_ADDR_W-1:0]   wr_addr_i,
  input  wire [`BFPC_WORD_W-1:0]   wr_data_i,
  input  wire [`BFPC_ADDR_W-1:0]   rd_addr_i,
  output reg  [`BFPC_WORD_W-1:0]   rd_data_o
);

  reg [`BFPC_WORD_W-1:0] mem [0:(1<<`BFPC_ADDR_W)-1];

  always @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule
`default_nettype wire

// >>> tb/bfpc_top_properties.sv
// checker for bfpc_top: parity flags, generated parity, empty timing
// assumes only the top ports and one clock domain
`timescale 1ns/100ps
`default_nettype none
module bfpc_top_properties (
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  input wire logic        odd_even_sel_i,
  input wire logic [35:0] port_a_bus_i,
  input wire logic [35:0] port_a_bus_o,
  input wire logic        port_a_bus_oe_n_o,
  input wire logic        port_a_chip_sel_n_i,
  input wire logic        port_a_write_read_i,
  input wire logic        port_a_enable_i,
  input wire logic        port_a_mailbox_sel_i,
  input wire logic        port_a_par_gen_sel_i,
  input wire logic        port_a_parity_err_n_o,
  input wire logic        port_a_full_n_o,
  input wire logic [35:0] port_b_bus_i,
  input wire logic [35:0] port_b_bus_o,
  input wire logic        port_b_chip_sel_n_i,
  input wire logic        port_b_write_read_i,
  input wire logic        port_b_enable_i,
  input wire logic        port_b_mailbox_sel_i,
  input wire logic        port_b_par_gen_sel_i,
  input wire logic        port_b_parity_err_n_o,
  input wire logic        port_b_empty_n_o
);
  wire rd_a = ~port_a_chip_sel_n_i & ~port_a_write_read_i & port_a_enable_i;
  wire rd_b = ~port_b_chip_sel_n_i & ~port_b_write_read_i & port_b_enable_i;
  wire gen_a = rd_a & port_a_mailbox_sel_i & port_a_par_gen_sel_i;
  wire gen_b = rd_b & port_b_mailbox_sel_i & port_b_par_gen_sel_i;
  wire wq_a = ~port_a_chip_sel_n_i & port_a_write_read_i & port_a_enable_i
              & ~port_a_mailbox_sel_i & port_a_full_n_o;
  function automatic logic bad(input logic [35:0] w, input logic odd);
    bad = 1'b0;
    for (int k = 0; k < 4; k++) bad = bad | ((^w[9*k +: 9]) != odd);
  endfunction
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // first edge after release still sees reset-time history
  sequence s_live; !$past(sys_rst_i); endsequence
  sequence s_fill_b; !port_b_empty_n_o && wq_a && !$past(wq_a); endsequence
  sequence s_gen_a; gen_a ##1 gen_a && $stable(odd_even_sel_i); endsequence
  sequence s_gen_b; gen_b ##1 gen_b && $stable(odd_even_sel_i); endsequence
  a_flag_a_calc: assert property (s_live |-> port_a_parity_err_n_o ==
    ($past(gen_a) || !bad($past(port_a_bus_i), $past(odd_even_sel_i))))
    else $error("port a parity flag wrong");
  a_flag_b_calc: assert property (s_live |-> port_b_parity_err_n_o ==
    ($past(gen_b) || !bad($past(port_b_bus_i), $past(odd_even_sel_i))))
    else $error("port b parity flag wrong");
  a_hold_a_flag: assert property (gen_a |=> port_a_parity_err_n_o)
    else $error("port a flag not held");
  a_hold_b_flag: assert property (gen_b |=> port_b_parity_err_n_o)
    else $error("port b flag not held");
  a_gen_a_par: assert property (s_gen_a |=> !bad(port_a_bus_o, $past(odd_even_sel_i)))
    else $error("port a mailbox parity wrong");
  a_gen_b_par: assert property (s_gen_b |=> !bad(port_b_bus_o, $past(odd_even_sel_i)))
    else $error("port b mailbox parity wrong");
  a_empty_b_rise: assert property (s_fill_b |=> !port_b_empty_n_o [*2] ##1 port_b_empty_n_o)
    else $error("port b empty flag timing wrong");
  a_drive_a_bus: assert property (rd_a ##1 rd_a |=> !port_a_bus_oe_n_o)
    else $error("port a bus not driven on read");
endmodule
bind bfpc_top bfpc_top_properties bfpc_top_properties_inst (.clock_i, .sys_rst_i,
  .odd_even_sel_i, .port_a_bus_i, .port_a_bus_o, .port_a_bus_oe_n_o, .port_a_chip_sel_n_i,
  .port_a_write_read_i, .port_a_enable_i, .port_a_mailbox_sel_i, .port_a_par_gen_sel_i,
  .port_a_parity_err_n_o, .port_a_full_n_o, .port_b_bus_i, .port_b_bus_o,
  .port_b_chip_sel_n_i, .port_b_write_read_i, .port_b_enable_i, .port_b_mailbox_sel_i,
  .port_b_par_gen_sel_i, .port_b_parity_err_n_o, .port_b_empty_n_o);
`default_nettype wire

// >>> tb/bfpc_host.sv
// host model for one port: drives the bus whenever the core does not
// assumes the core's output enable is active low
`timescale 1ns/100ps
`default_nettype none
module bfpc_host (
  input  wire logic [35:0] host_data_i,
  input  wire logic [35:0] dev_data_i,
  input  wire logic        dev_oe_n_i,
  input  wire logic        mb_req_i,
  output wire logic [35:0] bus_o,
  output wire logic        mb_sel_o
);
  // host backs off while the core drives, so no contention
  assign bus_o = dev_oe_n_i ? host_data_i : dev_data_i;
  assign mb_sel_o = mb_req_i;
endmodule
`default_nettype wire

// >>> tb/test_bfpc_top.sv
// self-checking bench for bfpc_top: random parity, mailboxes, queue a to b
// assumes bfpc_host on both ports and the bound checker
`timescale 1ns/100ps
`default_nettype none
module test_bfpc_top;
  // control bits: cs_n, write, enable, mailbox, generate
  localparam logic [4:0] IDLE = 5'h10, WR_Q = 5'h0c, WR_M = 5'h0e, RD_Q = 5'h04, RD_M = 5'h06;
  logic        clock_i = 1'b0, sys_rst_i = 1'b1, odd = 1'b1;
  logic [4:0]  ctl_a = IDLE, ctl_b = IDLE;
  logic [35:0] hd_a = 36'h0, hd_b = 36'h0, w;
  logic [35:0] mw [2];
  logic [63:0] rv;
  int          bad_count = 0, cmp_count = 0, n;
  wire  [35:0] a_i, a_o, b_i, b_o;
  wire         a_oe_n, b_oe_n, a_mb, b_mb, a_err_n, b_err_n, b_empty_n;
  wire         a_empty_n, a_full_n, a_afull_n, b_aempty_n;
  always #20 clock_i = ~clock_i;
  bfpc_host bfpc_host_a_inst (.host_data_i(hd_a), .dev_data_i(a_o), .dev_oe_n_i(a_oe_n),
    .mb_req_i(ctl_a[1]), .bus_o(a_i), .mb_sel_o(a_mb));
  bfpc_host bfpc_host_b_inst (.host_data_i(hd_b), .dev_data_i(b_o), .dev_oe_n_i(b_oe_n),
    .mb_req_i(ctl_b[1]), .bus_o(b_i), .mb_sel_o(b_mb));
  bfpc_top bfpc_top_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .odd_even_sel_i(odd),
    .port_a_bus_i(a_i), .port_a_bus_o(a_o), .port_a_bus_oe_n_o(a_oe_n),
    .port_a_chip_sel_n_i(ctl_a[4]), .port_a_write_read_i(ctl_a[3]), .port_a_enable_i(ctl_a[2]),
    .port_a_mailbox_sel_i(a_mb), .port_a_par_gen_sel_i(ctl_a[0]),
    .port_a_parity_err_n_o(a_err_n), .port_a_empty_n_o(a_empty_n), .port_a_full_n_o(a_full_n),
    .port_a_almost_empty_n_o(), .port_a_almost_full_n_o(a_afull_n),
    .port_b_bus_i(b_i), .port_b_bus_o(b_o), .port_b_bus_oe_n_o(b_oe_n),
    .port_b_chip_sel_n_i(ctl_b[4]), .port_b_write_read_i(ctl_b[3]), .port_b_enable_i(ctl_b[2]),
    .port_b_mailbox_sel_i(b_mb), .port_b_par_gen_sel_i(ctl_b[0]),
    .port_b_parity_err_n_o(b_err_n), .port_b_empty_n_o(b_empty_n), .port_b_full_n_o(),
    .port_b_almost_empty_n_o(b_aempty_n), .port_b_almost_full_n_o());
  function automatic logic bad(input logic [35:0] v, input logic o);
    bad = 1'b0;
    for (int k = 0; k < 4; k++) bad = bad | ((^v[9*k +: 9]) != o);
  endfunction
  function automatic logic [35:0] gen(input logic [35:0] v, input logic o);
    gen = v;
    for (int k = 0; k < 4; k++) gen[9*k+8] = (^v[9*k +: 8]) ^ o;
  endfunction
  task automatic cmp_word(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_word({35'h0, got}, {35'h0, exp});
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic set(input logic pb, input logic [4:0] c, input logic [35:0] d);
    @(negedge clock_i);
    if (pb) begin
      ctl_b = c;
      hd_b = d;
    end else begin
      ctl_a = c;
      hd_a = d;
    end
  endtask
  // generated read writes a fresh word; plain read re-reads it untouched
  task automatic mbox(input logic to_b, input logic pg);
    if (pg) begin
      rv = {$urandom, $urandom};
      mw[to_b] = rv[35:0];
      set(!to_b, WR_M, mw[to_b]);
      set(!to_b, IDLE, ~mw[to_b]);
    end
    set(to_b, RD_M | {4'h0, pg}, gen(~mw[to_b], !odd));
    @(negedge clock_i);
    if (pg) cmp_flag(to_b ? b_err_n : a_err_n, 1'b1);
    cmp_flag(to_b ? b_oe_n : a_oe_n, 1'b0);
    repeat (2) @(negedge clock_i);
    cmp_word(to_b ? b_o : a_o, pg ? gen(mw[to_b], odd) : mw[to_b]);
    set(to_b, IDLE, mw[to_b]);
  endtask
  task automatic qpass(input logic pg);
    rv = {$urandom, $urandom};
    w = rv[35:0];
    set(1'b0, WR_Q, w);
    n = 0;
    while (b_empty_n !== 1'b1 && n < 8) begin
      @(negedge clock_i);
      ctl_a = IDLE;
      hd_a = ~w;
      n++;
    end
    if (b_empty_n !== 1'b1) begin
      bad_count++;
      conclude();
    end
    cmp_flag(n == 3, 1'b1);
    cmp_flag(b_aempty_n, 1'b0);
    cmp_flag(a_full_n, 1'b1);
    cmp_flag(a_afull_n, 1'b1);
    cmp_flag(a_empty_n, 1'b0);
    set(1'b1, RD_Q | {4'h0, pg}, gen(~w, !odd));
    set(1'b1, IDLE | {4'h0, pg}, w);
    repeat (2) @(negedge clock_i);
    cmp_word(b_o, pg ? gen(w, odd) : w);
    cmp_flag(b_empty_n, 1'b0);
    set(1'b1, IDLE, w);
  endtask
  initial begin
    void'($urandom(32'hb09b));
    repeat (20) @(posedge clock_i);
    @(negedge clock_i);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 64; i++) begin
      rv = {$urandom, $urandom};
      @(negedge clock_i);
      odd = rv[63];
      hd_a = i < 2 ? {36{i[0]}} : rv[35:0];
      hd_b = rv[62:27];
      @(negedge clock_i);
      cmp_flag(a_err_n, !bad(hd_a, odd));
      cmp_flag(b_err_n, !bad(hd_b, odd));
    end
    for (int i = 0; i < 8; i++) begin
      odd = i[2];
      mbox(i[0], !i[1]);
    end
    for (int i = 0; i < 4; i++) begin
      odd = i[1];
      qpass(i[0]);
    end
    conclude();
  end
endmodule
`default_nettype wire
